// ===== bench/csso_exec_props.sv
// checker for bus reset, compare and search timing
// assumes binding onto csso_exec
`timescale 1ns/1ps
module csso_exec_props
    import csso_pkg::*;
#(parameter int DW = 32, parameter int PW = 16, parameter int ARGB = 8)
(
    // clock, reset, request
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [2:0] op_i,
    input wire logic [1:0] dtype_i,
    input wire logic [ARGB*8-1:0] first_operand_i,
    input wire logic [DW-1:0] second_operand_i,
    input wire logic [DW-1:0] third_operand_i,
    // results
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic [DW-1:0] dest_o,
    input wire logic dest_we_o,
    input wire logic pos_we_o,
    input wire logic io_reset_bit_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    logic tk;
    logic cmp;
    logic gt;
    logic eqv;
    assign tk = start_i && !busy_o;
    assign cmp = tk && op_i >= 3'h2 && op_i <= 3'h5;
    assign eqv = (first_operand_i[31:0] == second_operand_i);
    assign gt = (dtype_i == 2'h1) ? ($signed(first_operand_i[31:0]) > $signed(second_operand_i))
        : (first_operand_i[31:0] > second_operand_i);
    a_rst_low_len: assert property (tk && op_i == 3'h1 |=> (!io_reset_bit_o)[*8] ##1 (!io_reset_bit_o)[*8]
        ##1 io_reset_bit_o) else $error("io reset low length wrong");
    a_rst_busy_hold: assert property (tk && op_i == 3'h1 |=> busy_o && !done_o)
        else $error("bus reset not busy");
    a_rst_done_time: assert property (tk && op_i == 3'h1 |-> ##17 done_o && !dest_we_o)
        else $error("bus reset done timing wrong");
    a_cmp_answer: assert property (cmp |=> dest_we_o && done_o) else $error("compare answer missing");
    a_cmp_eq_res: assert property (tk && op_i == 3'h2 |=> dest_o[0] == $past(eqv))
        else $error("equal result wrong");
    a_cmp_ne_res: assert property (tk && op_i == 3'h3 |=> dest_o[0] == $past(!eqv))
        else $error("not equal result wrong");
    a_cmp_gt_res: assert property (tk && op_i == 3'h4 |=> dest_o[0] == $past(gt))
        else $error("greater result wrong");
    a_cmp_ge_res: assert property (tk && op_i == 3'h5 |=> dest_o[0] == $past(gt || eqv))
        else $error("greater equal result wrong");
    a_cmp_upper_kept: assert property (cmp |=> dest_o[31:1] == {$past(third_operand_i[31:8]), 7'h00})
        else $error("destination upper bits changed");
    a_pos_then_done: assert property (pos_we_o |=> done_o) else $error("search done missing");
    c_busrst: cover property (tk && op_i == 3'h1);
    c_cmp: cover property (cmp ##1 dest_we_o);
    c_search: cover property (tk && op_i == 3'h7);
endmodule
bind csso_exec csso_exec_props #(.DW(DW), .PW(PW), .ARGB(ARGB)) u_props (.*);

// ===== bench/test_compare_and_string_search_ops.sv
// self-checking bench for the compare and search execution block
// assumes csso_exec with default widths
`timescale 1ns/1ps
module test_compare_and_string_search_ops
    import csso_pkg::*;
;
    logic clk_sys_i = 0, rstn_i = 0, start_i = 0;
    logic [2:0] op_i = 0;
    logic [1:0] dtype_i = 0;
    logic [3:0] arg_len_i = 0;
    logic [63:0] first_operand_i = 0;
    logic [31:0] second_operand_i = 0, third_operand_i = 0, dest_o, dres, a, b, t;
    logic [15:0] str_len_i = 0, str_addr_o, pos_o, pres, lowc, sd = 16'd24802;
    logic [7:0] mem [0:31];
    logic [2:0] cop;
    logic [1:0] cdt;
    string txt = "HOW NOW BROWN COW.";
    logic busy_o, done_o, dest_we_o, pos_we_o, io_reset_bit_o;
    integer err_count = 0, total_checks = 0, k;
    always #12.5 clk_sys_i = ~clk_sys_i;
    csso_exec uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .start_i(start_i), .op_i(op_i), .dtype_i(dtype_i),
        .arg_len_i(arg_len_i), .first_operand_i(first_operand_i), .second_operand_i(second_operand_i),
        .third_operand_i(third_operand_i), .str_len_i(str_len_i), .str_addr_o(str_addr_o),
        .str_data_i(mem[str_addr_o[4:0]]), .busy_o(busy_o), .done_o(done_o), .dest_o(dest_o),
        .dest_we_o(dest_we_o), .pos_o(pos_o), .pos_we_o(pos_we_o), .io_reset_bit_o(io_reset_bit_o));
    function automatic logic [31:0] rnd();
        sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
        sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
        return {sd, sd[7:0] ^ sd[15:8], sd[15:8]};
    endfunction
    function automatic logic [63:0] pack(input string s);
        logic [63:0] r;
        r = 64'h0;
        for (int i = 0; i < 8 && i < s.len(); i++) r[i*8+:8] = s[i];
        return r;
    endfunction
    function automatic logic [31:0] exp_cmp(input logic [2:0] op, input logic [1:0] dt, input logic [31:0] x, y, z);
        logic g, r;
        g = (dt == 2'h1) ? ($signed(x) > $signed(y)) : (x > y);
        r = (op == 3'h2) ? (x == y) : (op == 3'h3) ? (x != y) : (op == 3'h4) ? g : (g || x == y);
        return {z[31:8], 7'h00, r};
    endfunction
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_pos(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic go(input logic [2:0] op, input logic [1:0] dt, input logic [3:0] ln, input logic [63:0] x,
        input logic [31:0] y, input logic [31:0] z);
        @(posedge clk_sys_i);
        start_i <= 1'b1;
        op_i <= op;
        dtype_i <= dt;
        arg_len_i <= ln;
        first_operand_i <= x;
        second_operand_i <= y;
        third_operand_i <= z;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        lowc = 16'h0;
        dres = 'x;
        pres = 'x;
        for (int n = 0; n < 60; n++) begin
            @(negedge clk_sys_i);
            if (io_reset_bit_o === 1'b0) lowc++;
            if (dest_we_o === 1'b1) dres = dest_o;
            if (pos_we_o === 1'b1) pres = pos_o;
            if (done_o === 1'b1) break;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #(25 * 5000);
        err_count++;
        wrap_up();
    end
    initial begin
        for (k = 0; k < 32; k++) mem[k] = 8'h2e;
        for (k = 0; k < 18; k++) mem[k] = txt[k];
        repeat (3) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        go(3'h1, 2'h0, 4'h0, 64'h0, 32'h0, 32'h0);
        chk_pos("io_low_cycles", 16'h0010, lowc);
        $display("test bus reset done");
        for (k = 0; k < 40; k++) begin
            a = rnd();
            b = (k % 5 == 0) ? a : rnd();
            t = rnd();
            cop = 3'(2 + k % 4);
            cdt = 2'(k % 3);
            if (cdt == 2'h0) {a, b} = {24'h0, a[7:0], 24'h0, b[7:0]};
            go(cop, cdt, 4'h0, {32'h0, a}, b, t);
            chk_word("compare", exp_cmp(cop, cdt, a, b, t), dres);
        end
        go(3'h4, 2'h1, 4'h0, 64'hffffffff, 32'h1, 32'h0);
        chk_word("signed_gt", 32'h0, dres);
        $display("test compares done");
        @(posedge clk_sys_i) str_len_i <= 16'h0012;
        go(3'h6, 2'h3, 4'h6, pack("NOW BR"), 32'hffff, 32'h0);
        chk_pos("find_first", 16'h0005, pres);
        go(3'h6, 2'h3, 4'hf, pack("NOW BROW"), 32'hffff, 32'h0);
        chk_pos("find_clamp", 16'h0005, pres);
        go(3'h6, 2'h0, 4'h0, pack("W"), 32'hffff, 32'h0);
        chk_pos("find_byte", 16'h0003, pres);
        go(3'h6, 2'h3, 4'hf, pack("NOW BROW"), 32'h0005, 32'h0);
        chk_pos("find_resume", 16'hfffe, pres);
        go(3'h6, 2'h1, 4'h0, pack("BROW"), 32'hffff, 32'h0);
        chk_pos("find_int", 16'h0009, pres);
        go(3'h7, 2'h3, 4'h4, pack("XYZW"), 32'hffff, 32'h0);
        chk_pos("set_first", 16'h0003, pres);
        go(3'h7, 2'h3, 4'h4, pack("XYZW"), 32'h0003, 32'h0);
        chk_pos("set_next", 16'h0007, pres);
        @(posedge clk_sys_i) str_len_i <= 16'h0006;
        go(3'h7, 2'h3, 4'h4, pack("XYZW"), 32'h0003, 32'h0);
        chk_pos("set_bounded", 16'hfffe, pres);
        $display("test searches done");
        wrap_up();
    end
endmodule

// ===== design/csso_cmp.sv
// boolean compare of two equal-width operands
// assumes operands already zero or sign extended to full width
`timescale 1ns/1ps
module csso_cmp
    import csso_pkg::*;
(
    csso_cmp_if.unit cmp
);
    logic gt;
    logic eq;
    always_comb begin
        eq = (cmp.a == cmp.b);
        if (cmp.sgn) begin
            gt = ($signed(cmp.a) > $signed(cmp.b)); // RULE_19
        end else begin
            gt = (cmp.a > cmp.b); // RULE_19
        end
        case (cmp.kind)
            2'h0: cmp.res = eq; // RULE_03
            2'h1: cmp.res = !eq; // RULE_04
            2'h2: cmp.res = gt; // RULE_05
            default: cmp.res = gt | eq; // RULE_06
        endcase
    end
endmodule

// ===== design/csso_cmp_if.sv
// carries the compare request and result between top and compare unit
// assumes one clock domain
`timescale 1ns/1ps
interface csso_cmp_if #(parameter int W = 32);
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic sgn;
    logic [1:0] kind;
    logic res;
    modport top (output a, output b, output sgn, output kind, input res);
    modport unit (input a, input b, input sgn, input kind, output res);
endinterface

// ===== design/csso_exec.sv
// execution logic for bus reset, compare and string search operations
// assumes operands fetched by the core; string bytes read one per cycle
// Behaviour
// RULE_01: bus reset drives io_reset_bit low exactly 16 cycles, then high.
// RULE_02: bus reset takes no operands at all.
// RULE_03: equal compare writes 01 when equal, else 00.
// RULE_04: not-equal compare writes 01 when different, else 00.
// RULE_05: greater compare writes 01 when first exceeds second, else 00.
// RULE_06: greater-or-equal compare writes 01 when first not below second.
// RULE_07: result in low bit; only destination least byte is changed.
// RULE_08: program gives both compare operands same type and length.
// RULE_09: program should give compare destinations byte type.
// RULE_10: find accepts byte, integer, ordinal or string argument; first occurrence.
// RULE_11: searched string length comes from its descriptor, bounding search.
// RULE_12: string argument uses only its first 8 bytes.
// RULE_13: search starts at second operand position; -1 means first byte.
// RULE_14: program loads start position before a search.
// RULE_15: find match stores positive byte position into second operand.
// RULE_16: set match stops at first byte in set, stores position.
// RULE_17: search finishing without match writes -2.
// RULE_18: positive start position resumes after that position.
// RULE_19: integers compare signed; byte and ordinal compare unsigned.
`timescale 1ns/1ps
`include "csso_map.svh"
module csso_exec
    import csso_pkg::*;
#(
    parameter int DW = 32,
    parameter int PW = 16,
    parameter int ARGB = `CSSO_ARG_MAX_BYTES
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // request
    input wire logic start_i,
    input wire logic [2:0] op_i,
    input wire logic [1:0] dtype_i,
    input wire logic [3:0] arg_len_i,
    input wire logic [ARGB*8-1:0] first_operand_i,
    input wire logic [DW-1:0] second_operand_i,
    input wire logic [DW-1:0] third_operand_i,
    input wire logic [PW-1:0] str_len_i,
    // string byte read port
    output logic [PW-1:0] str_addr_o,
    input wire logic [7:0] str_data_i,
    // results
    output logic busy_o,
    output logic done_o,
    output logic [DW-1:0] dest_o,
    output logic dest_we_o,
    output logic [PW-1:0] pos_o,
    output logic pos_we_o,
    output logic io_reset_bit_o
);
    typedef struct packed {
        csso_state_t st;
        csso_op_t op;
        logic [4:0] rcnt;
        logic [PW-1:0] idx;
        logic [PW-1:0] len;
        logic [ARGB*8-1:0] arg;
        logic [3:0] alen;
        logic [ARGB*8-1:0] win;
        logic [3:0] wcnt;
        logic [DW-1:0] dest;
        logic dest_we;
        logic [PW-1:0] pos;
        logic pos_we;
        logic done;
        logic io_rst;
    } csso_state_s_t;

    csso_state_s_t cur_ff;
    csso_state_s_t nxt_cur;
    csso_cmp_if #(.W(DW)) cmp_bus();

    csso_cmp u_cmp (
        .cmp(cmp_bus.unit)
    );

    // argument length in bytes from the operand type
    function automatic logic [3:0] arg_bytes(input logic [1:0] dt, input logic [3:0] sl);
        case (dt)
            CSSO_DT_BYTE: arg_bytes = 4'h1;
            CSSO_DT_INT, CSSO_DT_ORD: arg_bytes = 4'((DW / 8));
            default: arg_bytes = (sl > 4'(ARGB)) ? 4'(ARGB) : ((sl == 4'h0) ? 4'h1 : sl); // RULE_12
        endcase
    endfunction

    // byte k of the packed argument
    function automatic logic [7:0] arg_byte(input logic [ARGB*8-1:0] v, input int k);
        arg_byte = v[k*8 +: 8];
    endfunction

    always_comb begin
        cmp_bus.b = second_operand_i;
        cmp_bus.a = first_operand_i[DW-1:0];
        cmp_bus.sgn = (dtype_i == CSSO_DT_INT); // RULE_19
        // opcodes 2..5 map to unit kinds 0 eq, 1 ne, 2 gt, 3 ge
        cmp_bus.kind = op_i[1:0] ^ 2'h2;
    end

    logic set_hit;
    logic str_hit;
    logic [ARGB*8-1:0] win_new;
    always_comb begin
        win_new = {cur_ff.win[ARGB*8-9:0], str_data_i};
        set_hit = 1'b0;
        str_hit = 1'b1;
        for (int k = 0; k < ARGB; k++) begin
            if (k < int'(cur_ff.alen) && arg_byte(cur_ff.arg, k) == str_data_i) begin
                set_hit = 1'b1; // RULE_16
            end
            // window holds last bytes, newest in byte 0; arg byte 0 is first
            if (k < int'(cur_ff.alen) && arg_byte(win_new, k) != arg_byte(cur_ff.arg, int'(cur_ff.alen) - 1 - k)) begin
                str_hit = 1'b0; // RULE_10
            end
        end
        if (cur_ff.wcnt + 4'h1 < cur_ff.alen) begin
            str_hit = 1'b0;
        end
    end

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.dest_we = 1'b0;
        nxt_cur.pos_we = 1'b0;
        nxt_cur.done = 1'b0;
        case (cur_ff.st)
            CSSO_ST_IDLE: begin
                if (start_i) begin
                    nxt_cur.op = csso_op_t'(op_i);
                    case (csso_op_t'(op_i))
                        CSSO_OP_BUSRST_E: begin
                            // no operand fetch at all
                            nxt_cur.rcnt = 5'(`CSSO_IO_RESET_CYCLES); // RULE_02
                            nxt_cur.io_rst = 1'b0; // RULE_01
                            nxt_cur.st = CSSO_ST_RST;
                        end
                        CSSO_OP_CMP_EQ_E, CSSO_OP_CMP_NE_E, CSSO_OP_CMP_GT_E, CSSO_OP_CMP_GE_E: begin
                            nxt_cur.dest = {third_operand_i[DW-1:8], 7'h00, cmp_bus.res}; // RULE_07
                            nxt_cur.dest_we = 1'b1;
                            nxt_cur.done = 1'b1;
                        end
                        CSSO_OP_FIND_E, CSSO_OP_SETM_E: begin
                            nxt_cur.arg = first_operand_i;
                            nxt_cur.alen = arg_bytes(dtype_i, arg_len_i); // RULE_12
                            nxt_cur.len = str_len_i; // RULE_11
                            nxt_cur.win = '0;
                            nxt_cur.wcnt = 4'h0;
                            if (second_operand_i[PW-1:0] == `CSSO_POS_START || second_operand_i[PW-1]) begin
                                nxt_cur.idx = '0; // RULE_13
                            end else if (csso_op_t'(op_i) == CSSO_OP_FIND_E) begin
                                // positions are 1-based; resume after the previous match start
                                nxt_cur.idx = second_operand_i[PW-1:0]; // RULE_18
                            end else begin
                                nxt_cur.idx = second_operand_i[PW-1:0]; // RULE_18
                            end
                            nxt_cur.st = CSSO_ST_SCAN;
                        end
                        default: begin
                            nxt_cur.done = 1'b1;
                        end
                    endcase
                end
            end
            CSSO_ST_SCAN: begin
                if (cur_ff.idx >= cur_ff.len) begin
                    nxt_cur.pos = `CSSO_POS_DONE; // RULE_17
                    nxt_cur.pos_we = 1'b1;
                    nxt_cur.st = CSSO_ST_DONE;
                end else begin
                    nxt_cur.win = win_new;
                    nxt_cur.wcnt = (cur_ff.wcnt == 4'(ARGB)) ? cur_ff.wcnt : cur_ff.wcnt + 4'h1;
                    nxt_cur.idx = cur_ff.idx + 1'b1;
                    if (cur_ff.op == CSSO_OP_SETM_E && set_hit) begin
                        nxt_cur.pos = cur_ff.idx + 1'b1; // RULE_16
                        nxt_cur.pos_we = 1'b1;
                        nxt_cur.st = CSSO_ST_DONE;
                    end else if (cur_ff.op == CSSO_OP_FIND_E && str_hit) begin
                        nxt_cur.pos = PW'(cur_ff.idx + 2'd2 - PW'(cur_ff.alen)); // RULE_15
                        nxt_cur.pos_we = 1'b1;
                        nxt_cur.st = CSSO_ST_DONE;
                    end
                end
            end
            CSSO_ST_DONE: begin
                nxt_cur.done = 1'b1;
                nxt_cur.st = CSSO_ST_IDLE;
            end
            CSSO_ST_RST: begin
                nxt_cur.rcnt = cur_ff.rcnt - 5'h01;
                if (cur_ff.rcnt == 5'h01) begin
                    nxt_cur.io_rst = 1'b1; // RULE_01
                    nxt_cur.done = 1'b1;
                    nxt_cur.st = CSSO_ST_IDLE;
                end
            end
            default: begin
                nxt_cur.st = CSSO_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_ff <= '{st: CSSO_ST_IDLE, op: CSSO_OP_NONE_E, io_rst: 1'b1, default: '0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign str_addr_o = cur_ff.idx;
    assign busy_o = (cur_ff.st != CSSO_ST_IDLE);
    assign done_o = cur_ff.done;
    assign dest_o = cur_ff.dest;
    assign dest_we_o = cur_ff.dest_we;
    assign pos_o = cur_ff.pos;
    assign pos_we_o = cur_ff.pos_we;
    assign io_reset_bit_o = cur_ff.io_rst;
endmodule

// ===== design/csso_map.svh
// constants for the compare and string search execution block
// assumes inclusion by the package and the modules that need numbers
`ifndef CSSO_MAP_SVH
`define CSSO_MAP_SVH
`define CSSO_IO_RESET_CYCLES 16
`define CSSO_TRUE_BYTE 8'h01
`define CSSO_FALSE_BYTE 8'h00
`define CSSO_ARG_MAX_BYTES 8
`define CSSO_POS_START 16'hffff
`define CSSO_POS_DONE 16'hfffe
`define CSSO_OP_NONE 3'h0
`define CSSO_OP_BUSRST 3'h1
`define CSSO_OP_CMP_EQ 3'h2
`define CSSO_OP_CMP_NE 3'h3
`define CSSO_OP_CMP_GT 3'h4
`define CSSO_OP_CMP_GE 3'h5
`define CSSO_OP_FIND 3'h6
`define CSSO_OP_SETM 3'h7
`endif

// ===== design/csso_pkg.sv
// types for the compare and string search execution block
// assumes csso_map.svh is on the include path
`include "csso_map.svh"
package csso_pkg;
    typedef enum logic [2:0] {
        CSSO_OP_NONE_E = `CSSO_OP_NONE,
        CSSO_OP_BUSRST_E = `CSSO_OP_BUSRST,
        CSSO_OP_CMP_EQ_E = `CSSO_OP_CMP_EQ,
        CSSO_OP_CMP_NE_E = `CSSO_OP_CMP_NE,
        CSSO_OP_CMP_GT_E = `CSSO_OP_CMP_GT,
        CSSO_OP_CMP_GE_E = `CSSO_OP_CMP_GE,
        CSSO_OP_FIND_E = `CSSO_OP_FIND,
        CSSO_OP_SETM_E = `CSSO_OP_SETM
    } csso_op_t;
    typedef enum logic [1:0] {
        CSSO_DT_BYTE = 2'h0,
        CSSO_DT_INT = 2'h1,
        CSSO_DT_ORD = 2'h2,
        CSSO_DT_STR = 2'h3
    } csso_dtype_t;
    typedef enum logic [3:0] {
        CSSO_ST_IDLE = 4'b0001,
        CSSO_ST_SCAN = 4'b0010,
        CSSO_ST_DONE = 4'b0100,
        CSSO_ST_RST = 4'b1000
    } csso_state_t;
endpackage
